//--- core/crb_pkg.sv
package crb_pkg;

    // ------------------------------------------------------------
    // Address space and reset values
    // ------------------------------------------------------------
    localparam int          CRB_PC_W        = 16;
    localparam logic [15:0] CRB_PC_RESET    = 16'h0000;

    // ------------------------------------------------------------
    // Opcodes handled by this unit
    // ------------------------------------------------------------
    localparam logic [7:0]  CRB_OP_CARRY_CLEAR = 8'h50;
    localparam logic [7:0]  CRB_OP_ACC_NONZERO = 8'h70;

    // ------------------------------------------------------------
    // Instruction shape and timing
    // ------------------------------------------------------------
    localparam int          CRB_INSTR_BYTES  = 2;
    localparam int          CRB_MC_PER_INSTR = 2;
    localparam int          CRB_CLKS_PER_MC  = 12;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        CRB_ST_IDLE = 3'b001,
        CRB_ST_MC1  = 3'b010,
        CRB_ST_MC2  = 3'b100
    } crb_state_t;

endpackage

//--- core/crb_target_calc.sv
`timescale 1ns/10ps

module crb_target_calc
    import crb_pkg::*;
#(
    parameter int PC_W = CRB_PC_W
)
(
    input  wire logic [PC_W-1:0] pc_opcode,
    input  wire logic [7:0]      rel_disp,
    output wire logic [PC_W-1:0] pc_seq,
    output wire logic [PC_W-1:0] pc_target
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (PC_W < 8)
    begin : g_bad_width
        $error("crb_target_calc: PC_W must be at least 8");
    end

    localparam logic [PC_W-1:0] STEP = PC_W'(CRB_INSTR_BYTES);

    // ------------------------------------------------------------
    // Target arithmetic
    // ------------------------------------------------------------
    wire logic [PC_W-1:0] rel_sext;

    // Both sums wrap modulo the address space by truncation to PC_W.
    assign pc_seq    = pc_opcode + STEP;
    assign rel_sext  = {{(PC_W-8){rel_disp[7]}}, rel_disp};
    assign pc_target = pc_seq + rel_sext;

endmodule

//--- core/crb_branch_unit.sv
`timescale 1ns/10ps
// Overview of operation
// - Carry-clear jump branches when carry is zero, else falls through.
// - Target is opcode address plus two, plus the signed second-byte displacement.
// - Carry-clear jump never writes the carry flag, taken or not.
// - Opcode 50h is the carry-clear jump, two bytes, two machine cycles.
// - Accumulator-nonzero jump branches when any accumulator bit is one.
// - Accumulator-nonzero jump writes neither accumulator nor any flag.
// - Opcode 70h is the accumulator-nonzero jump, two bytes, two machine cycles.

module crb_branch_unit
    import crb_pkg::*;
#(
    parameter int PC_W        = CRB_PC_W,
    parameter int CLKS_PER_MC = CRB_CLKS_PER_MC
)
(
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic            dec_valid,
    input  wire logic [7:0]      dec_opcode,
    input  wire logic [7:0]      dec_rel,
    input  wire logic [PC_W-1:0] dec_pc,
    input  wire logic            carry_flag,
    input  wire logic [7:0]      acc_value,
    output wire logic            dec_ready,
    output wire logic            dec_hit,
    output wire logic            busy,
    output wire logic            mc_end,
    output wire logic            pc_load,
    output logic      [PC_W-1:0] pc_next_r,
    output logic                 branch_taken_r,
    output logic                 op_carry_r,
    output logic                 carry_wr_en_r,
    output logic                 acc_wr_en_r,
    output logic                 flags_wr_en_r
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CLKS_PER_MC < 1)
    begin : g_bad_mc
        $error("crb_branch_unit: CLKS_PER_MC must be at least 1");
    end
    if (PC_W < 8)
    begin : g_bad_pc
        $error("crb_branch_unit: PC_W must be at least 8");
    end
    if (CRB_MC_PER_INSTR != 2)
    begin : g_bad_seq
        $error("crb_branch_unit: sequencer is built for two machine cycles");
    end

    localparam int             CNT_W    = (CLKS_PER_MC > 1) ? $clog2(CLKS_PER_MC) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CLKS_PER_MC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    crb_state_t       state_r;
    crb_state_t       state_nxt;
    logic [CNT_W-1:0] clk_cnt_r;
    logic [CNT_W-1:0] clk_cnt_nxt;

    wire logic            st_idle;
    wire logic            st_mc1;
    wire logic            st_mc2;
    wire logic            is_carry_op;
    wire logic            is_acc_op;
    wire logic            accept;
    wire logic            cond_carry;
    wire logic            cond_acc;
    wire logic            cond_true;
    wire logic [PC_W-1:0] pc_seq;
    wire logic [PC_W-1:0] pc_target;
    wire logic [PC_W-1:0] pc_sel;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign st_idle     = (state_r == CRB_ST_IDLE);
    assign st_mc1      = (state_r == CRB_ST_MC1);
    assign st_mc2      = (state_r == CRB_ST_MC2);

    assign is_carry_op = (dec_opcode == CRB_OP_CARRY_CLEAR);
    assign is_acc_op   = (dec_opcode == CRB_OP_ACC_NONZERO);
    assign dec_hit     = is_carry_op | is_acc_op;
    assign dec_ready   = st_idle;
    assign accept      = dec_valid & dec_ready & dec_hit;

    // The condition is sampled at acceptance; the core may alter
    // carry or accumulator while the instruction is still in flight.
    assign cond_carry  = ~carry_flag;
    assign cond_acc    = |acc_value;
    assign cond_true   = is_carry_op ? cond_carry : cond_acc;

    // ------------------------------------------------------------
    // Target calculation
    // ------------------------------------------------------------
    crb_target_calc #(
        .PC_W      (PC_W)
    ) crb_target_calc_i (
        .pc_opcode (dec_pc),
        .rel_disp  (dec_rel),
        .pc_seq    (pc_seq),
        .pc_target (pc_target)
    );

    // Not taken continues at the byte after the displacement.
    assign pc_sel = cond_true ? pc_target : pc_seq;

    // ------------------------------------------------------------
    // Machine-cycle sequencer
    // ------------------------------------------------------------
    assign mc_end  = (st_mc1 | st_mc2) & (clk_cnt_r == CNT_LAST);
    assign pc_load = st_mc2 & mc_end;
    assign busy    = ~st_idle;

    always_comb
    begin
        state_nxt   = state_r;
        clk_cnt_nxt = clk_cnt_r;
        case (state_r)
            CRB_ST_IDLE:
            begin
                clk_cnt_nxt = CNT_ZERO;
                if (accept)
                begin
                    state_nxt = CRB_ST_MC1;
                end
            end
            CRB_ST_MC1:
            begin
                if (mc_end)
                begin
                    clk_cnt_nxt = CNT_ZERO;
                    state_nxt   = CRB_ST_MC2;
                end
                else
                begin
                    clk_cnt_nxt = clk_cnt_r + CNT_W'(1);
                end
            end
            CRB_ST_MC2:
            begin
                if (mc_end)
                begin
                    clk_cnt_nxt = CNT_ZERO;
                    state_nxt   = CRB_ST_IDLE;
                end
                else
                begin
                    clk_cnt_nxt = clk_cnt_r + CNT_W'(1);
                end
            end
            default:
            begin
                clk_cnt_nxt = CNT_ZERO;
                state_nxt   = CRB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= CRB_ST_IDLE;
            clk_cnt_r <= CNT_ZERO;
        end
        else
        begin
            state_r   <= state_nxt;
            clk_cnt_r <= clk_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // The result is captured at acceptance so that later changes on the
    // decode inputs cannot disturb an instruction already in flight.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_next_r      <= PC_W'(CRB_PC_RESET);
            branch_taken_r <= 1'b0;
            op_carry_r     <= 1'b0;
        end
        else if (accept)
        begin
            pc_next_r      <= pc_sel;
            branch_taken_r <= cond_true;
            op_carry_r     <= is_carry_op;
        end
    end

    // ------------------------------------------------------------
    // Architectural write enables
    // ------------------------------------------------------------
    // Neither branch writes back: the tested carry, the accumulator and
    // all other flags keep their values, so these enables stay low.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            carry_wr_en_r <= 1'b0;
            acc_wr_en_r   <= 1'b0;
            flags_wr_en_r <= 1'b0;
        end
        else
        begin
            carry_wr_en_r <= 1'b0;
            acc_wr_en_r   <= 1'b0;
            flags_wr_en_r <= 1'b0;
        end
    end

endmodule

//--- test/crb_branch_unit_assertions.sv
`timescale 1ns/10ps
module crb_branch_unit_chk
    import crb_pkg::*;
#(
    parameter int PC_W        = CRB_PC_W,
    parameter int CLKS_PER_MC = CRB_CLKS_PER_MC
)
(
    input wire logic            core_clk,
    input wire logic            rst_n,
    input wire logic            dec_valid,
    input wire logic [7:0]      dec_opcode,
    input wire logic [7:0]      dec_rel,
    input wire logic [PC_W-1:0] dec_pc,
    input wire logic            carry_flag,
    input wire logic [7:0]      acc_value,
    input wire logic            dec_ready,
    input wire logic            dec_hit,
    input wire logic            busy,
    input wire logic            mc_end,
    input wire logic            pc_load,
    input wire logic [PC_W-1:0] pc_next_r,
    input wire logic            branch_taken_r,
    input wire logic            op_carry_r,
    input wire logic            carry_wr_en_r,
    input wire logic            acc_wr_en_r,
    input wire logic            flags_wr_en_r
);
    // Counts clocks since the last accept; saturates so it never aliases a later op.
    logic [7:0]      cnt_r;
    wire logic [7:0] cnt_nxt;
    wire logic       accept  = dec_valid && dec_ready && dec_hit;
    wire logic       is_cc   = dec_opcode == CRB_OP_CARRY_CLEAR;
    wire logic       cond    = is_cc ? !carry_flag : (acc_value != 8'h00);
    wire logic [PC_W-1:0] exp_nxt = dec_pc + PC_W'(2)
        + (cond ? {{(PC_W-8){dec_rel[7]}}, dec_rel} : '0);
    assign cnt_nxt = accept ? 8'h01
                   : ((cnt_r != 8'h00 && cnt_r != 8'hFF) ? cnt_r + 8'h01 : cnt_r);
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) cnt_r <= 8'h00;
        else cnt_r <= cnt_nxt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_hit_decode: assert property (
        dec_hit == (is_cc || dec_opcode == CRB_OP_ACC_NONZERO))
        else $error("opcode decode wrong");
    a_load_timing: assert property (
        pc_load == (cnt_r == 8'(2*CLKS_PER_MC)))
        else $error("pc load at wrong cycle");
    a_mc_end_cycle: assert property (
        mc_end == (cnt_r == 8'(CLKS_PER_MC) || cnt_r == 8'(2*CLKS_PER_MC)))
        else $error("machine cycle end at wrong cycle");
    a_busy_span: assert property (
        busy == (cnt_r != 8'h00 && cnt_r <= 8'(2*CLKS_PER_MC)) && dec_ready == !busy)
        else $error("busy span wrong");
    a_carry_cond: assert property (
        accept && is_cc |=> op_carry_r && branch_taken_r == !$past(carry_flag))
        else $error("carry clear condition wrong");
    a_acc_cond: assert property (
        accept && !is_cc |=> !op_carry_r && branch_taken_r == ($past(acc_value) != 8'h00))
        else $error("acc nonzero condition wrong");
    a_target_calc: assert property (
        accept |=> pc_next_r == $past(exp_nxt))
        else $error("next pc wrong");
    a_hold_result: assert property (
        !accept |=> $stable(pc_next_r) && $stable(branch_taken_r) && $stable(op_carry_r))
        else $error("result changed without accept");
    a_no_writes: assert property (
        !(carry_wr_en_r || acc_wr_en_r || flags_wr_en_r))
        else $error("flag or acc write");
endmodule
bind crb_branch_unit crb_branch_unit_chk #(.PC_W(PC_W), .CLKS_PER_MC(CLKS_PER_MC)) chk_i (
    .core_clk(core_clk), .rst_n(rst_n), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_rel(dec_rel), .dec_pc(dec_pc), .carry_flag(carry_flag), .acc_value(acc_value),
    .dec_ready(dec_ready), .dec_hit(dec_hit), .busy(busy), .mc_end(mc_end), .pc_load(pc_load),
    .pc_next_r(pc_next_r), .branch_taken_r(branch_taken_r), .op_carry_r(op_carry_r),
    .carry_wr_en_r(carry_wr_en_r), .acc_wr_en_r(acc_wr_en_r), .flags_wr_en_r(flags_wr_en_r));

//--- test/crb_branch_unit_test.sv
`timescale 1ns/10ps
module crb_branch_unit_test;
    import crb_pkg::*;
    logic        core_clk = 0, rst_n = 0, dec_valid = 0, carry_flag = 0;
    logic [7:0]  dec_opcode = 8'h00, dec_rel = 8'h00, acc_value = 8'h00, op, rel_v, acc_v;
    logic [15:0] dec_pc = 16'h0000, pc_v;
    logic        c_v;
    logic [17:0] exp_e;
    logic [20:0] rst_snap;
    wire logic   dec_ready, dec_hit, busy, mc_end, pc_load, taken, op_cc, cw, aw, fw;
    wire logic [15:0] pc_next_r;
    logic [17:0] exp_q[$];
    int          fails = 0, tests_run = 0, cycles = 0, n;
    crb_branch_unit #(.PC_W(16), .CLKS_PER_MC(2)) crb_branch_unit_i (
        .core_clk(core_clk), .rst_n(rst_n), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
        .dec_rel(dec_rel), .dec_pc(dec_pc), .carry_flag(carry_flag), .acc_value(acc_value),
        .dec_ready(dec_ready), .dec_hit(dec_hit), .busy(busy), .mc_end(mc_end),
        .pc_load(pc_load), .pc_next_r(pc_next_r), .branch_taken_r(taken), .op_carry_r(op_cc),
        .carry_wr_en_r(cw), .acc_wr_en_r(aw), .flags_wr_en_r(fw));
    initial forever #12.5 core_clk = ~core_clk;
    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            fails++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // -------------------------------------------------------------
    // Driver: one request, then, if it hit, a refused request while busy.
    // -------------------------------------------------------------
    task automatic run_op(input logic [7:0] o, r, input logic [15:0] pc, input logic c,
                          input logic [7:0] a);
        logic hit;
        logic tk;
        hit = (o == 8'h50) || (o == 8'h70);
        tk = (o == 8'h50) ? !c : (a != 8'h00);
        n = 0;
        while (dec_ready !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        dec_valid  = 1;
        dec_opcode = o;
        dec_rel    = r;
        dec_pc     = pc;
        carry_flag = c;
        acc_value  = a;
        #1 check(dec_hit === hit, "opcode decode");
        if (hit)
            exp_q.push_back({o == CRB_OP_CARRY_CLEAR, tk,
                             pc + 16'(CRB_INSTR_BYTES) + (tk ? {{8{r[7]}}, r} : 16'h0000)});
        @(negedge core_clk);
        check(busy === hit, "busy after request");
        // A refused request while busy must leave the captured result alone.
        dec_opcode = CRB_OP_ACC_NONZERO;
        acc_value  = 8'hFF;
        dec_pc     = 16'($urandom);
        if (!hit) dec_valid = 0;
        @(negedge core_clk);
        dec_valid  = 0;
        carry_flag = 1'($urandom);
        acc_value  = 8'($urandom);
        // Let an edge pass so the next call never reassigns in this time step.
        @(negedge core_clk);
    endtask
    always @(negedge core_clk)
        if (pc_load === 1'b1)
        begin
            check({cw, aw, fw} === 3'b000, "flag or acc write");
            if (exp_q.size() == 0) check(0, "unexpected pc load");
            else
            begin
                exp_e = exp_q.pop_front();
                check({op_cc, taken, pc_next_r} === exp_e, "bad result");
            end
        end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            give_verdict;
        end
    end
    initial
    begin
        void'($urandom(32'h7BD6DAE4));
        repeat (12) @(negedge core_clk);
        rst_n = 1;
        run_op(8'h50, 8'hFE, 16'h1000, 1'b0, 8'h00);
        run_op(8'h50, 8'hFE, 16'h1000, 1'b1, 8'h00);
        run_op(8'h70, 8'h7F, 16'hFFFF, 1'b0, 8'h80);
        run_op(8'h70, 8'h80, 16'h0001, 1'b1, 8'h00);
        run_op(8'h50, 8'h80, 16'h0000, 1'b0, 8'h01);
        run_op(8'h60, 8'h10, 16'h2000, 1'b0, 8'h00);
        // Reset in mid-flight drops the pending result and returns everything to idle.
        run_op(8'h70, 8'h05, 16'h3000, 1'b0, 8'h01);
        rst_n = 0;
        exp_q.delete();
        #1 rst_snap = {busy, dec_ready, pc_load, op_cc, taken, pc_next_r};
        check(rst_snap === 21'h080000, "reset state");
        @(negedge core_clk);
        rst_n = 1;
        repeat (80)
        begin
            case ($urandom % 3)
                0: op = 8'h50;
                1: op = 8'h70;
                default: op = 8'($urandom);
            endcase
            rel_v = 8'($urandom);
            pc_v  = 16'($urandom);
            c_v   = 1'($urandom);
            acc_v = ($urandom % 2) ? 8'h00 : 8'($urandom);
            run_op(op, rel_v, pc_v, c_v, acc_v);
        end
        n = 0;
        while (exp_q.size() != 0 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        check(exp_q.size() == 0, "missing pc load");
        give_verdict;
    end
endmodule
